// ===== dv/ext_mem_model.sv
// Behavioural external program and data memory on the far bus.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  input  wire logic                    mclk_i,
  input  wire mem_map_pkg::mem_route_t route_i,
  input  wire logic                    sel_n_i,
  input  wire logic [15:0]             addr_i,
  output logic [7:0]                   rdata_o
);
  logic [7:0] last_q;
  // An idle bus shows the inverse of its last value, never a held copy.
  always_comb begin
    if (!route_i.to_external) begin
      rdata_o = ~last_q;
    end else if (!sel_n_i) begin
      rdata_o = ~addr_i[7:0] ^ 8'h5a;
    end else begin
      rdata_o = addr_i[7:0];
    end
  end
  always_ff @(posedge mclk_i) begin
    last_q <= rdata_o;
  end
endmodule
`default_nettype wire

// ===== dv/mem_map_asserts.sv
// Concurrent checks on the ports of the memory map and protection block.
`timescale 1ns/1ps
`default_nettype none
module mem_map_asserts (
  input wire logic                    mclk_i,
  input wire logic                    reset_n_i,
  input wire logic                    stop_recover_i,
  input wire logic                    rom_protect_opt_i,
  input wire logic                    ram_protect_opt_i,
  input wire logic                    dsel_func_en_i,
  input wire logic                    pc_exec_ext_i,
  input wire mem_map_pkg::reg_req_t   reg_req_i,
  input wire mem_map_pkg::mem_req_t   mem_req_i,
  input wire logic                    pc_load_o,
  input wire logic [15:0]             pc_value_o,
  input wire logic [7:0]              reg_rdata_o,
  input wire logic                    reg_blocked_o,
  input wire mem_map_pkg::mem_route_t route_o,
  input wire logic [15:0]             stack_ptr_o,
  input wire logic                    port_line_o,
  input wire logic                    ram_protect_on_o,
  input wire logic                    no_int_prog_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  logic acc;
  logic lock;
  logic tbl;
  logic dat;
  logic rom;
  assign acc = reg_req_i.wr | reg_req_i.rd;
  assign lock = acc && reg_req_i.addr >= 8'h80 && reg_req_i.addr <= 8'hef
    && ram_protect_opt_i && ram_protect_on_o;
  assign tbl = mem_req_i.valid && (mem_req_i.kind == mem_map_pkg::ACC_PCONST
    || mem_req_i.kind == mem_map_pkg::ACC_PCONST_INC);
  assign dat = mem_req_i.valid && (mem_req_i.kind == mem_map_pkg::ACC_XDATA
    || mem_req_i.kind == mem_map_pkg::ACC_XDATA_INC);
  // Below 1000h is internal for every size, so no size decode is needed.
  assign rom = tbl && mem_req_i.addr < 16'h1000 && rom_protect_opt_i
    && !no_int_prog_o;
  AST_BLOCK: assert property (lock |=> reg_blocked_o && reg_rdata_o == 8'h00)
    else $error("protected access not blocked");
  AST_PASS: assert property (acc && !lock |=> !reg_blocked_o)
    else $error("access blocked without cause");
  AST_IMC: assert property (reg_req_i.wr && reg_req_i.addr == 8'hfb |=>
    ram_protect_on_o == $past(reg_req_i.wdata[6]))
    else $error("protect switch not following bit six");
  AST_ROM_EXT: assert property (rom && pc_exec_ext_i |=>
    route_o.blocked && !route_o.to_internal)
    else $error("table read from outside not refused");
  AST_ROM_INT: assert property (rom && !pc_exec_ext_i |=>
    route_o.to_internal && !route_o.blocked)
    else $error("table read from inside refused");
  AST_DSEL_LOW: assert property (dat && dsel_func_en_i |=>
    !port_line_o && route_o.data_space)
    else $error("data load did not assert select");
  AST_DSEL_HIGH: assert property (tbl && dsel_func_en_i |=> port_line_o)
    else $error("constant load asserted select");
  AST_SP: assert property (stop_recover_i |=> stack_ptr_o == 16'h0000)
    else $error("stack pointer not cleared");
  AST_PC: assert property (pc_load_o |-> pc_value_o == 16'h000c)
    else $error("wrong start address");
  cover property (lock);
  cover property (rom && pc_exec_ext_i);
  cover property (stop_recover_i);
endmodule
bind memory_map_protection mem_map_asserts u_chk (.mclk_i, .reset_n_i,
  .stop_recover_i, .rom_protect_opt_i, .ram_protect_opt_i, .dsel_func_en_i,
  .pc_exec_ext_i, .reg_req_i, .mem_req_i, .pc_load_o, .pc_value_o,
  .reg_rdata_o, .reg_blocked_o, .route_o, .stack_ptr_o, .port_line_o,
  .ram_protect_on_o, .no_int_prog_o);
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the memory map and protection block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                    mclk_i = 1'b0;
  logic                    reset_n_i = 1'b0;
  logic                    stop_recover_i = 1'b0;
  logic                    no_int_prog_i = 1'b0;
  mem_map_pkg::mem_size_t  mem_size_i = mem_map_pkg::SIZE_8K;
  logic                    rom_protect_opt_i = 1'b1;
  logic                    ram_protect_opt_i = 1'b1;
  logic                    dsel_func_en_i = 1'b1;
  logic                    ext_stack_i = 1'b1;
  logic                    port_line_i = 1'b1;
  logic                    pc_exec_ext_i = 1'b0;
  mem_map_pkg::reg_req_t   reg_req_i = '0;
  mem_map_pkg::mem_req_t   mem_req_i = '0;
  mem_map_pkg::mem_route_t route_o;
  logic                    pc_load_o;
  logic                    reg_hit_o;
  logic                    reg_blocked_o;
  logic                    stack_bound_err_o;
  logic                    port_line_o;
  logic                    ram_protect_on_o;
  logic                    no_int_prog_o;
  logic [15:0]             pc_value_o;
  logic [15:0]             stack_ptr_o;
  logic [15:0]             addr_q = '0;
  logic [7:0]              reg_rdata_o;
  logic [7:0]              xdata;
  int                      n_errors = 0;
  int                      compares = 0;
  always #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (mem_req_i.valid) addr_q <= mem_req_i.addr;
  memory_map_protection uut (.mclk_i, .reset_n_i, .stop_recover_i,
    .no_int_prog_i, .mem_size_i, .rom_protect_opt_i, .ram_protect_opt_i,
    .dsel_func_en_i, .ext_stack_i, .port_line_i, .reg_req_i, .mem_req_i,
    .pc_exec_ext_i, .pc_load_o, .pc_value_o, .reg_rdata_o, .reg_hit_o,
    .reg_blocked_o, .route_o, .stack_ptr_o, .stack_bound_err_o,
    .port_line_o, .ram_protect_on_o, .no_int_prog_o);
  ext_mem_model u_mem (.mclk_i(mclk_i), .route_i(route_o),
    .sel_n_i(port_line_o), .addr_i(addr_q), .rdata_o(xdata));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i) reg_req_i <= '{1'b1, 1'b0, a, d};
    @(posedge mclk_i) reg_req_i <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [8:0] e,
                    input logic [8:0] m = 9'h1ff);
    @(posedge mclk_i) reg_req_i <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk_i) reg_req_i <= '0;
    @(negedge mclk_i) chk({reg_blocked_o, reg_rdata_o} & m, e);
  endtask
  task automatic mr(input mem_map_pkg::acc_kind_t k, input logic [15:0] a,
                    input logic [4:0] e, input logic [4:0] m = 5'h1f);
    @(posedge mclk_i) mem_req_i <= '{1'b1, k, a};
    @(posedge mclk_i) mem_req_i <= '0;
    @(negedge mclk_i) chk({route_o, port_line_o} & m, e);
  endtask
  // Flags are registered from the pointer, so let one more edge pass.
  task automatic err(input logic e);
    @(posedge mclk_i);
    @(negedge mclk_i) chk(stack_bound_err_o, e);
  endtask
  task automatic conclude;
    if (n_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge mclk_i);
    n_errors++;
    conclude;
  end
  initial begin
    repeat (20) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    @(negedge mclk_i) chk({pc_load_o, pc_value_o}, 17'h1000c);
    chk(stack_ptr_o, 16'h0000);
    repeat (2) @(posedge mclk_i);
    mr(mem_map_pkg::ACC_FETCH, 16'h0000, 5'b10001);
    mr(mem_map_pkg::ACC_FETCH, 16'h1fff, 5'b10001);
    mr(mem_map_pkg::ACC_FETCH, 16'h2000, 5'b01001);
    chk(xdata, 8'h00);
    mr(mem_map_pkg::ACC_XDATA, 16'h2000, 5'b01010);
    chk(xdata, 8'ha5);
    mr(mem_map_pkg::ACC_PCONST_INC, 16'h0100, 5'b10001);
    pc_exec_ext_i <= 1'b1;
    mr(mem_map_pkg::ACC_PCONST, 16'h0100, 5'b00100, 5'b10100);
    mr(mem_map_pkg::ACC_PCONST_INC, 16'h0fff, 5'b00100, 5'b10100);
    mr(mem_map_pkg::ACC_XDATA, 16'h0100, 5'b01010);
    mr(mem_map_pkg::ACC_XDATA_INC, 16'h0100, 5'b01010);
    rom_protect_opt_i <= 1'b0;
    mr(mem_map_pkg::ACC_PCONST, 16'h0100, 5'b10001);
    wr(8'hfb, 8'h40);
    rd(8'hfb, 9'h040);
    rd(8'h80, 9'h100);
    chk(reg_hit_o, 1'b0);
    rd(8'hef, 9'h100);
    rd(8'h7f, 9'h000, 9'h100);
    rd(8'hff, 9'h000);
    ram_protect_opt_i <= 1'b0;
    rd(8'h90, 9'h000, 9'h100);
    ram_protect_opt_i <= 1'b1;
    wr(8'hfb, 8'h00);
    rd(8'h80, 9'h000, 9'h100);
    wr(8'hfe, 8'h12);
    wr(8'hff, 8'h34);
    rd(8'hfe, 9'h012);
    chk(reg_hit_o, 1'b1);
    chk(stack_ptr_o, 16'h1234);
    err(1'b1);
    wr(8'hfe, 8'h20);
    err(1'b0);
    ext_stack_i <= 1'b0;
    wr(8'hff, 8'h02);
    err(1'b1);
    wr(8'hff, 8'hef);
    err(1'b0);
    wr(8'hfe, 8'h5c);
    rd(8'hfe, 9'h05c);
    @(posedge mclk_i) stop_recover_i <= 1'b1;
    @(posedge mclk_i) stop_recover_i <= 1'b0;
    @(negedge mclk_i) chk({pc_load_o, stack_ptr_o}, 17'h10000);
    @(posedge mclk_i) reset_n_i <= 1'b0;
    no_int_prog_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    no_int_prog_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i) chk(no_int_prog_o, 1'b1);
    mr(mem_map_pkg::ACC_FETCH, 16'h0100, 5'b01001);
    mr(mem_map_pkg::ACC_XDATA, 16'hffff, 5'b01010);
    chk(xdata, 8'h5a);
    dsel_func_en_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    mr(mem_map_pkg::ACC_XDATA_INC, 16'h4000, 5'b01011);
    conclude;
  end
endmodule
`default_nettype wire

// ===== logic/mem_map_pkg.sv
// Constants and types for the memory map and protection block.
package mem_map_pkg;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [7:0] IMC_ADDR      = 8'hfb;
  localparam logic [7:0] STACK_HI_ADDR = 8'hfe;
  localparam logic [7:0] SPL_ADDR      = 8'hff;
  localparam int         IMC_RAMP_BIT  = 6;
  localparam logic [7:0] IMC_RESET     = 8'h00;
  localparam logic [7:0] SP_RESET      = 8'h00;
  localparam logic [7:0] PROT_LO       = 8'h80;
  localparam logic [7:0] PROT_HI       = 8'hef;
  localparam logic [7:0] GPR_LO        = 8'h04;
  localparam logic [7:0] GPR_HI        = 8'hef;

  // ****************************************************************
  // Program and data memory map
  // ****************************************************************
  localparam logic [15:0] VECTOR_BYTES = 16'h000c;
  localparam logic [15:0] START_PC     = 16'h000c;
  localparam logic [15:0] TOP_4K       = 16'h0fff;
  localparam logic [15:0] TOP_8K       = 16'h1fff;
  localparam logic [15:0] TOP_16K      = 16'h3fff;
  localparam logic [15:0] SPACE_TOP    = 16'hffff;

  typedef enum logic [1:0] {
    SIZE_4K  = 2'h0,
    SIZE_8K  = 2'h1,
    SIZE_16K = 2'h2
  } mem_size_t;

  typedef enum logic [2:0] {
    ACC_FETCH = 3'h0,
    ACC_PCONST     = 3'h1,
    ACC_PCONST_INC = 3'h2,
    ACC_XDATA      = 3'h3,
    ACC_XDATA_INC  = 3'h4
  } acc_kind_t;

  // Core's request for a program or data space access.
  typedef struct packed {
    logic        valid;
    acc_kind_t   kind;
    logic [15:0] addr;
  } mem_req_t;

  // Routing decision for that access.
  typedef struct packed {
    logic        to_internal;
    logic        to_external;
    logic        blocked;
    logic        data_space;
  } mem_route_t;

  // Register file access from the core.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// ===== logic/memory_map_protection.sv
// Address map, read protection, RAM protect and stack pointer logic.
`timescale 1ns/1ps
`default_nettype none
module memory_map_protection (
  input  wire logic                   mclk_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   stop_recover_i,
  input  wire logic                   no_int_prog_i,
  input  wire mem_map_pkg::mem_size_t mem_size_i,
  input  wire logic                   rom_protect_opt_i,
  input  wire logic                   ram_protect_opt_i,
  input  wire logic                   dsel_func_en_i,
  input  wire logic                   ext_stack_i,
  input  wire logic                   port_line_i,
  input  wire mem_map_pkg::reg_req_t  reg_req_i,
  input  wire mem_map_pkg::mem_req_t  mem_req_i,
  input  wire logic                   pc_exec_ext_i,
  output logic                        pc_load_o,
  output logic [15:0]                 pc_value_o,
  output logic [7:0]                  reg_rdata_o,
  output logic                        reg_hit_o,
  output logic                        reg_blocked_o,
  output mem_map_pkg::mem_route_t     route_o,
  output logic [15:0]                 stack_ptr_o,
  output logic                        stack_bound_err_o,
  output logic                        port_line_o,
  output logic                        ram_protect_on_o,
  output logic                        no_int_prog_o
);

  // ****************************************************************
  // Strap capture and start address
  // ****************************************************************
  logic        strap_meta_q;
  logic        strap_sync_q;
  logic        no_int_q;
  logic        boot_q;
  logic [1:0]  boot_cnt_q;
  logic        pc_load_q;
  logic [15:0] pc_value_q;

  // Two flops guard the asynchronous strap pin before it is latched.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strap_meta_q <= 1'b0;
      strap_sync_q <= 1'b0;
    end else begin
      strap_meta_q <= no_int_prog_i;
      strap_sync_q <= strap_meta_q;
    end
  end

  // The mode latches on the third edge after release, once the strap has
  // crossed both synchroniser flops, and then holds for the run.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      boot_q     <= 1'b1;
      boot_cnt_q <= 2'h0;
      no_int_q   <= 1'b0;
    end else begin
      boot_q <= 1'b0;
      if (boot_cnt_q != 2'h3) begin
        boot_cnt_q <= boot_cnt_q + 2'h1;
      end
      if (boot_cnt_q == 2'h2) begin
        no_int_q <= strap_sync_q;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pc_load_q  <= 1'b0;
      pc_value_q <= 16'h0000;
    end else begin
      pc_load_q  <= boot_q | stop_recover_i;
      pc_value_q <= mem_map_pkg::START_PC;
    end
  end

  // ****************************************************************
  // Program and data space decode
  // ****************************************************************
  logic [15:0] int_top;
  logic        kind_pconst;
  logic        kind_xdata;
  logic        in_internal;
  logic        table_read;
  logic        table_blocked;
  mem_map_pkg::mem_route_t route_d;
  mem_map_pkg::mem_route_t route_q;

  always_comb begin
    case (mem_size_i)
      mem_map_pkg::SIZE_4K:  int_top = mem_map_pkg::TOP_4K;
      mem_map_pkg::SIZE_8K:  int_top = mem_map_pkg::TOP_8K;
      mem_map_pkg::SIZE_16K: int_top = mem_map_pkg::TOP_16K;
      default:               int_top = mem_map_pkg::TOP_4K;
    endcase
  end

  assign kind_pconst = (mem_req_i.kind == mem_map_pkg::ACC_PCONST) ||
                       (mem_req_i.kind == mem_map_pkg::ACC_PCONST_INC);
  assign kind_xdata  = (mem_req_i.kind == mem_map_pkg::ACC_XDATA) ||
                       (mem_req_i.kind == mem_map_pkg::ACC_XDATA_INC);
  // Vectors occupy 0..000Bh inside the internal array.
  // Data loads address external data at every address, below the internal top as well.
  // With no internal program everything goes out, 64 KB wide.
  assign in_internal = !no_int_q && (mem_req_i.addr <= int_top) &&
                       !kind_xdata;
  assign table_read  = kind_pconst || kind_xdata;
  assign table_blocked = rom_protect_opt_i && pc_exec_ext_i &&
                         table_read && in_internal;

  always_comb begin
    route_d             = '0;
    route_d.data_space  = mem_req_i.valid && kind_xdata;
    route_d.blocked     = mem_req_i.valid && table_blocked;
    route_d.to_internal = mem_req_i.valid && in_internal && !table_blocked;
    route_d.to_external = mem_req_i.valid && !in_internal;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      route_q <= '0;
    end else begin
      route_q <= route_d;
    end
  end

  // ****************************************************************
  // Data-space select on the port line
  // ****************************************************************
  logic port_sync_meta_q;
  logic port_sync_q;
  logic port_line_q;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      port_sync_meta_q <= 1'b0;
      port_sync_q      <= 1'b0;
    end else begin
      port_sync_meta_q <= port_line_i;
      port_sync_q      <= port_sync_meta_q;
    end
  end

  // Select is active low; idle and program loads hold it high.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      port_line_q <= 1'b1;
    end else if (dsel_func_en_i) begin
      port_line_q <= !(route_d.data_space);
    end else begin
      port_line_q <= port_sync_q;
    end
  end

  // ****************************************************************
  // Control registers and RAM protect
  // ****************************************************************
  logic [7:0] imc_q;
  logic [7:0] stack_hi_q;
  logic [7:0] spl_q;
  logic       ramp_on;
  logic       in_prot;
  logic       blocked;
  logic       is_ctrl;
  logic [7:0] rdata_q;
  logic       hit_q;
  logic       blk_q;

  // Protection only takes effect when the option was programmed.
  assign ramp_on = ram_protect_opt_i && imc_q[mem_map_pkg::IMC_RAMP_BIT];
  assign in_prot = (reg_req_i.addr >= mem_map_pkg::PROT_LO) &&
                   (reg_req_i.addr <= mem_map_pkg::PROT_HI);
  assign blocked = ramp_on && in_prot;
  assign is_ctrl = (reg_req_i.addr == mem_map_pkg::IMC_ADDR) ||
                   (reg_req_i.addr == mem_map_pkg::STACK_HI_ADDR) ||
                   (reg_req_i.addr == mem_map_pkg::SPL_ADDR);

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      imc_q <= mem_map_pkg::IMC_RESET;
    end else if (reg_req_i.wr && reg_req_i.addr == mem_map_pkg::IMC_ADDR) begin
      imc_q <= reg_req_i.wdata;
    end
  end

  // Stop recovery is a synchronous clear beside the asynchronous reset.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stack_hi_q <= mem_map_pkg::SP_RESET;
      spl_q      <= mem_map_pkg::SP_RESET;
    end else if (stop_recover_i) begin
      stack_hi_q <= mem_map_pkg::SP_RESET;
      spl_q      <= mem_map_pkg::SP_RESET;
    end else if (reg_req_i.wr) begin
      if (reg_req_i.addr == mem_map_pkg::STACK_HI_ADDR) begin
        stack_hi_q <= reg_req_i.wdata;
      end
      if (reg_req_i.addr == mem_map_pkg::SPL_ADDR) begin
        spl_q <= reg_req_i.wdata;
      end
    end
  end

  // Read data for the control registers; the general file lives outside,
  // so a blocked read forces zero over whatever it returns.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= 8'h00;
      hit_q   <= 1'b0;
      blk_q   <= 1'b0;
    end else begin
      hit_q <= reg_req_i.rd && is_ctrl;
      blk_q <= (reg_req_i.rd || reg_req_i.wr) && blocked;
      if (reg_req_i.rd && reg_req_i.addr == mem_map_pkg::IMC_ADDR) begin
        rdata_q <= imc_q;
      end else if (reg_req_i.rd &&
                   reg_req_i.addr == mem_map_pkg::STACK_HI_ADDR) begin
        rdata_q <= stack_hi_q;
      end else if (reg_req_i.rd && reg_req_i.addr == mem_map_pkg::SPL_ADDR) begin
        rdata_q <= spl_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  // ****************************************************************
  // Stack placement and bounds
  // ****************************************************************
  logic [15:0] sp_full;
  logic [15:0] data_base;
  logic        err_q;

  assign sp_full   = ext_stack_i ? {stack_hi_q, spl_q} :
                                   {8'h00, spl_q};
  assign data_base = no_int_q ? 16'h0000 : int_top + 16'h0001;

  // A stack outside its legal window is flagged, not corrected.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      err_q <= 1'b0;
    end else if (ext_stack_i) begin
      err_q <= (sp_full < data_base);
    end else begin
      err_q <= (spl_q < mem_map_pkg::GPR_LO) ||
               (spl_q > mem_map_pkg::GPR_HI);
    end
  end

  assign pc_load_o         = pc_load_q;
  assign pc_value_o        = pc_value_q;
  assign reg_rdata_o       = rdata_q;
  assign reg_hit_o         = hit_q;
  assign reg_blocked_o     = blk_q;
  assign route_o           = route_q;
  assign stack_ptr_o       = {stack_hi_q, spl_q};
  assign stack_bound_err_o = err_q;
  assign port_line_o       = port_line_q;
  assign ram_protect_on_o  = imc_q[mem_map_pkg::IMC_RAMP_BIT];
  assign no_int_prog_o     = no_int_q;

endmodule
`default_nettype wire
